// [include/pms_pkg.sv]
`default_nettype none
package pms_pkg;
	localparam int NUM_PORTS = 12;
	localparam int CPU_PORT  = 11;
	localparam int NUM_VIDS  = 4096;

	localparam logic [11:0] OFF_INGRESS_EN  = 12'h000;
	localparam logic [11:0] OFF_EGRESS_MASK = 12'h004;
	localparam logic [11:0] OFF_TARGET_MASK = 12'h008;
	localparam logic [11:0] OFF_CTRL        = 12'h00c;
	localparam logic [11:0] OFF_COPY_COUNT  = 12'h010;
	localparam logic [2:0]  VID_REGION      = 3'h2;

	localparam int CTRL_CPU_COPY   = 0;
	localparam int CTRL_LEARN_COPY = 1;
	localparam int CTRL_QUEUE_LSB  = 4;
	localparam int CTRL_QUEUE_W    = 3;

	localparam logic [11:0] RST_INGRESS_EN  = 12'h000;
	localparam logic [11:0] RST_EGRESS_MASK = 12'h000;
	localparam logic [11:0] RST_TARGET_MASK = 12'h000;
	localparam logic [2:0]  RST_CPU_QUEUE   = 3'h0;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;

	typedef struct packed {
		logic [11:0]         ingressCopyEnable;
		logic [11:0]         egressCopyMask;
		logic [11:0]         copyTargetMask;
		logic                cpuCopy;
		logic                learnCopy;
		logic [2:0]          copyCpuQueue;
		logic [31:0]         copyCount;
		logic [NUM_VIDS-1:0] vidCopyFlag;
		logic                phWrite;
		logic                phActive;
		logic [11:0]         phAddr;
		logic [31:0]         rdata;
		logic                outValid;
		logic [11:0]         outFwdMask;
		logic [11:0]         outCopyMask;
		logic                outCpuCopy;
		logic [2:0]          outCpuQueue;
	} pms_state_t;
endpackage
`default_nettype wire

// [hw/pms_port_mirror_selector.sv]
// How it works
// (RQ1) Frames received on a port with ingress copy enable go to copy targets.
// (RQ2) Frames forwarded to a port in the egress copy mask go to targets.
// (RQ3) Frames classified to a VID whose copy flag is set go to targets.
// (RQ4) With CPU-bound copy on, frames for any CPU queue go to targets.
// (RQ5) With learn copy on, frames to be learned also go to targets.
// (RQ6) A matching content classifier entry action triggers a copy to targets.
// (RQ7) Any port, CPU included, may be a copy target; usually one bit set.
// (RQ8) Copies to the CPU use the configured copy CPU queue.
// (RQ9) Probe port with both directions enabled sends both to the target.
// (RQ10) Software sets target egress tagging and remarking like the probe port.
// (RQ11) Many triggers may be active at once towards the same target.
// (RQ12) Several triggers give one copy per target; original forwarding kept.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pms_port_mirror_selector
	import pms_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        inValid,
	output logic             inReady,
	input  wire logic [3:0]  inSrcPort,
	input  wire logic [11:0] inFwdMask,
	input  wire logic [11:0] inVid,
	input  wire logic        inCpuBound,
	input  wire logic        inLearnFrame,
	input  wire logic        inClassifierCopy,
	output logic             outValid,
	input  wire logic        outReady,
	output logic      [11:0] outFwdMask,
	output logic      [11:0] outCopyMask,
	output logic             outCpuCopy,
	output logic      [2:0]  outCpuQueue
);
	pms_state_t  st;
	pms_state_t  nxt;
	logic        fire;
	logic        ingressHit;
	logic        egressHit;
	logic        vidHit;
	logic        cpuHit;
	logic        learnHit;
	logic        anyTrigger;
	logic        busWrite;
	logic        rdReq;
	logic [31:0] vidWord;

	// A source port number beyond the port count selects nothing.
	function automatic logic portBit(input logic [11:0] mask,
	                                 input logic [3:0]  port);
		portBit = (port < 4'(NUM_PORTS)) ? mask[port] : 1'b0;
	endfunction

	function automatic logic inVidRegion(input logic [11:0] addr);
		inVidRegion = (addr[11:9] == VID_REGION);
	endfunction

	function automatic logic [31:0] readWord(input pms_state_t s,
	                                         input logic [11:0] addr);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (inVidRegion(addr)) begin
			w = s.vidCopyFlag[{addr[8:2], 5'h00} +: 32];
		end else begin
			unique case (addr)
				OFF_INGRESS_EN:  w[11:0] = s.ingressCopyEnable;
				OFF_EGRESS_MASK: w[11:0] = s.egressCopyMask;
				OFF_TARGET_MASK: w[11:0] = s.copyTargetMask;
				OFF_CTRL: begin
					w[CTRL_CPU_COPY] = s.cpuCopy;
					w[CTRL_LEARN_COPY] = s.learnCopy;
					w[CTRL_QUEUE_LSB +: CTRL_QUEUE_W] = s.copyCpuQueue;
				end
				OFF_COPY_COUNT:  w = s.copyCount;
				default:         w = 32'h0000_0000;
			endcase
		end
		readWord = w;
	endfunction

	assign inReady = !st.outValid || outReady;
	assign fire    = inValid && inReady;

	// Each trigger is evaluated on its own; they are merged by a single OR.
	assign ingressHit = portBit(st.ingressCopyEnable, inSrcPort); // [RQ1] [RQ9]
	assign egressHit  = |(inFwdMask & st.egressCopyMask);         // [RQ2] [RQ9]
	assign vidHit     = st.vidCopyFlag[inVid];                    // [RQ3]
	assign cpuHit     = st.cpuCopy && inCpuBound;                 // [RQ4]
	assign learnHit   = st.learnCopy && inLearnFrame;             // [RQ5]
	assign anyTrigger = ingressHit || egressHit || vidHit || cpuHit
	                    || learnHit || inClassifierCopy;          // [RQ6] [RQ11]

	always_comb begin
		nxt = st;
		if (st.phActive && st.phWrite) begin
			if (inVidRegion(st.phAddr)) begin
				nxt.vidCopyFlag[{st.phAddr[8:2], 5'h00} +: 32] = hwdata; // [RQ3]
			end else begin
				unique case (st.phAddr)
					OFF_INGRESS_EN:  nxt.ingressCopyEnable = hwdata[11:0];
					OFF_EGRESS_MASK: nxt.egressCopyMask = hwdata[11:0];
					OFF_TARGET_MASK: nxt.copyTargetMask = hwdata[11:0]; // [RQ7]
					OFF_CTRL: begin
						nxt.cpuCopy = hwdata[CTRL_CPU_COPY];
						nxt.learnCopy = hwdata[CTRL_LEARN_COPY];
						nxt.copyCpuQueue =
							hwdata[CTRL_QUEUE_LSB +: CTRL_QUEUE_W];
					end
					OFF_COPY_COUNT:  nxt.copyCount = 32'h0000_0000;
					default: begin
					end
				endcase
			end
		end
		nxt.phActive = hsel && (htrans == HTRANS_NONSEQ) && hready;
		nxt.phWrite = hwrite;
		nxt.phAddr = haddr[11:0];
		// Reading from the updated copy keeps a read right behind a write
		// to the same word from returning the old value.
		if (nxt.phActive && !hwrite) begin
			nxt.rdata = readWord(nxt, haddr[11:0]);
		end
		if (inReady) begin
			nxt.outValid = inValid;
		end
		if (fire) begin
			nxt.outFwdMask = inFwdMask; // [RQ12]
			// One mask bit per target port, however many triggers hit.
			nxt.outCopyMask = anyTrigger ? st.copyTargetMask
			                             : 12'h000; // [RQ12] [RQ11]
			nxt.outCpuCopy = anyTrigger && st.copyTargetMask[CPU_PORT];
			nxt.outCpuQueue = st.copyCpuQueue; // [RQ8]
			// The count runs after a software clear so a hit is not lost.
			if (anyTrigger) begin
				nxt.copyCount = nxt.copyCount + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st <= '0;
			st.ingressCopyEnable <= RST_INGRESS_EN;
			st.egressCopyMask <= RST_EGRESS_MASK;
			st.copyTargetMask <= RST_TARGET_MASK;
			st.copyCpuQueue <= RST_CPU_QUEUE;
		end else begin
			st <= nxt;
		end
	end

	assign hreadyout   = 1'b1;
	assign hresp       = HRESP_OKAY;
	assign hrdata      = st.rdata;
	assign outValid    = st.outValid;
	assign outFwdMask  = st.outFwdMask;
	assign outCopyMask = st.outCopyMask;
	assign outCpuCopy  = st.outCpuCopy;
	assign outCpuQueue = st.outCpuQueue;

	// Terms shared by the checks below; nothing in the datapath reads them.
	assign busWrite = st.phActive && st.phWrite;
	assign rdReq    = hsel && (htrans == HTRANS_NONSEQ) && hready && !hwrite;
	assign vidWord  = st.vidCopyFlag[{st.phAddr[8:2], 5'h00} +: 32];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_ingress_copy: assert property ( // [RQ1]
		fire && ingressHit |=> outValid
			&& outCopyMask == $past(st.copyTargetMask))
		else $error("ingress copy not made");

	a_egress_copy: assert property ( // [RQ2]
		fire && egressHit |=> outValid
			&& outCopyMask == $past(st.copyTargetMask))
		else $error("egress copy not made");

	a_vid_copy: assert property ( // [RQ3]
		fire && st.vidCopyFlag[inVid] |=>
			outCopyMask == $past(st.copyTargetMask))
		else $error("vid copy not made");

	a_cpu_bound: assert property ( // [RQ4]
		fire && st.cpuCopy && inCpuBound |=>
			outCopyMask == $past(st.copyTargetMask))
		else $error("cpu bound copy not made");

	a_learn_copy: assert property ( // [RQ5]
		fire && st.learnCopy && inLearnFrame |=>
			outCopyMask == $past(st.copyTargetMask))
		else $error("learn frame copy not made");

	a_class_copy: assert property ( // [RQ6]
		fire && inClassifierCopy |=>
			outCopyMask == $past(st.copyTargetMask))
		else $error("classifier copy not made");

	a_cpu_queue: assert property ( // [RQ8]
		fire && anyTrigger && st.copyTargetMask[CPU_PORT] |=>
			outCpuCopy && outCpuQueue == $past(st.copyCpuQueue))
		else $error("cpu copy queue wrong");

	a_no_trigger: assert property ( // [RQ12]
		fire && !anyTrigger |=> outCopyMask == 12'h000 && !outCpuCopy)
		else $error("copy without trigger");

	a_fwd_kept: assert property ( // [RQ12]
		fire |=> outValid && outFwdMask == $past(inFwdMask))
		else $error("forward mask altered");

	a_stall_hold: assert property (
		outValid && !outReady |=> outValid && $stable(outFwdMask)
			&& $stable(outCopyMask) && $stable(outCpuQueue))
		else $error("output changed under stall");

	a_count_step: assert property (
		fire && anyTrigger && !(st.phActive && st.phWrite) |=>
			st.copyCount == $past(st.copyCount) + 32'h0000_0001)
		else $error("copy count did not step");

	// Register writes commit at the end of the data phase, so each write
	// is compared in the next cycle against the data of that phase.
	a_ingress_write: assert property ( // [RQ1]
		busWrite && st.phAddr == OFF_INGRESS_EN |=>
			st.ingressCopyEnable == $past(hwdata[11:0]))
		else $error("ingress enable not written");

	a_egress_write: assert property ( // [RQ2]
		busWrite && st.phAddr == OFF_EGRESS_MASK |=>
			st.egressCopyMask == $past(hwdata[11:0]))
		else $error("egress mask not written");

	a_target_write: assert property ( // [RQ7]
		busWrite && st.phAddr == OFF_TARGET_MASK |=>
			st.copyTargetMask == $past(hwdata[11:0]))
		else $error("target mask not written");

	a_ctrl_write: assert property ( // [RQ4] [RQ5] [RQ8]
		busWrite && st.phAddr == OFF_CTRL |=>
			st.cpuCopy == $past(hwdata[CTRL_CPU_COPY])
			&& st.learnCopy == $past(hwdata[CTRL_LEARN_COPY])
			&& st.copyCpuQueue
				== $past(hwdata[CTRL_QUEUE_LSB +: CTRL_QUEUE_W]))
		else $error("control word not written");

	// The address phase register loads haddr every cycle, so the check holds
	// only while the address stays put and the written flag word is still selected one cycle later.
	a_vid_write: assert property ( // [RQ3]
		busWrite && inVidRegion(st.phAddr)
			##1 st.phAddr == $past(st.phAddr) |-> vidWord == $past(hwdata))
		else $error("vid flag word not written");

	a_count_clear: assert property (
		busWrite && st.phAddr == OFF_COPY_COUNT && !(fire && anyTrigger)
			|=> st.copyCount == 32'h0000_0000)
		else $error("copy count not cleared");

	// A hit in the clearing cycle is counted rather than lost.
	a_count_wins: assert property (
		busWrite && st.phAddr == OFF_COPY_COUNT && fire && anyTrigger
			|=> st.copyCount == 32'h0000_0001)
		else $error("copy count lost a hit");

	a_count_hold: assert property (
		!busWrite && !(fire && anyTrigger) |=> $stable(st.copyCount))
		else $error("copy count moved");

	a_config_hold: assert property ( // [RQ7]
		!busWrite |=> $stable(st.copyTargetMask)
			&& $stable(st.ingressCopyEnable) && $stable(st.egressCopyMask))
		else $error("configuration moved without write");

	a_read_hold: assert property (
		!rdReq |=> $stable(hrdata))
		else $error("read data moved without read");

	a_read_count: assert property (
		rdReq && haddr[11:0] == OFF_COPY_COUNT && !busWrite |=>
			hrdata == $past(st.copyCount))
		else $error("copy count read wrong");

	a_read_target: assert property ( // [RQ7]
		rdReq && haddr[11:0] == OFF_TARGET_MASK && !busWrite |=>
			hrdata == {20'h00000, $past(st.copyTargetMask)})
		else $error("target mask read wrong");

	a_out_drain: assert property ( // [RQ12]
		outValid && outReady && !fire |=> !outValid)
		else $error("output held after drain");

	a_stall_refuse: assert property ( // [RQ12]
		outValid && !outReady |-> !inReady)
		else $error("frame taken under stall");

	a_both_dir: assert property ( // [RQ9] [RQ11]
		fire && ingressHit && egressHit |=> outValid
			&& outCopyMask == $past(st.copyTargetMask))
		else $error("probe port copy not made");

	a_multi_cause: assert property ( // [RQ11]
		fire && vidHit && inClassifierCopy |=>
			outCopyMask == $past(st.copyTargetMask))
		else $error("merged triggers gave wrong copy");

	// These name the trigger terms one by one, so a broken merge of the
	// triggers is caught even where the merged flag looks clean.
	a_no_cause: assert property ( // [RQ12]
		fire && !ingressHit && !egressHit && !vidHit && !cpuHit
			&& !learnHit && !inClassifierCopy |=> outCopyMask == 12'h000)
		else $error("copy made with no cause");

	a_learn_off: assert property ( // [RQ5]
		fire && inLearnFrame && !st.learnCopy && !ingressHit && !egressHit
			&& !vidHit && !cpuHit && !inClassifierCopy
			|=> outCopyMask == 12'h000)
		else $error("learn frame copied while off");

	a_cpu_off: assert property ( // [RQ4]
		fire && inCpuBound && !st.cpuCopy && !ingressHit && !egressHit
			&& !vidHit && !learnHit && !inClassifierCopy
			|=> outCopyMask == 12'h000 && !outCpuCopy)
		else $error("cpu bound frame copied while off");

	a_no_cpu_copy: assert property ( // [RQ8]
		fire && !st.copyTargetMask[CPU_PORT] |=> !outCpuCopy)
		else $error("cpu copy without cpu target");

	a_out_queue: assert property ( // [RQ8]
		fire |=> outCpuQueue == $past(st.copyCpuQueue))
		else $error("copy queue not taken");

	c_ingress: cover property (fire && ingressHit && !egressHit);
	c_both_dir: cover property (fire && ingressHit && egressHit);
	c_cpu_target: cover property (outValid && outCpuCopy);
	c_stall: cover property (outValid && !outReady ##1 outValid && outReady);
	c_multi: cover property (fire && vidHit && cpuHit);
endmodule
`default_nettype wire

// [bench/pms_egress_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pms_egress_model
	import pms_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic stall,
	output logic      outReady
);
	// Egress queues push back now and then, so the selector must hold its
	// output until taken.
	// Copies are taken to leave exactly as the originals do: the target
	// port is assumed set up for tagging and remarking like the probe.
	always_ff @(posedge clk) begin
		outReady <= rst ? 1'b1 : !stall;
	end
endmodule
`default_nettype wire

// [bench/port_mirror_selector_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module port_mirror_selector_tb;
	import pms_pkg::*;
	logic        clk, rst, hsel, hwrite, inValid, inCpuBound, inLearnFrame;
	logic        inClassifierCopy, stall, hreadyout, hresp, inReady;
	logic        outValid, outReady, outCpuCopy, flag;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize, outCpuQueue;
	logic [3:0]  inSrcPort;
	logic [11:0] inFwdMask, inVid, outFwdMask, outCopyMask, ing, egr, tgt;
	logic [6:0]  ctl;
	logic [27:0] e;
	logic [27:0] q[$];
	int          n_fail, comparisons, cyc, nCopy;

	pms_port_mirror_selector dut(.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.inValid, .inReady, .inSrcPort, .inFwdMask, .inVid, .inCpuBound,
		.inLearnFrame, .inClassifierCopy, .outValid, .outReady, .outFwdMask,
		.outCopyMask, .outCpuCopy, .outCpuQueue);
	pms_egress_model egress(.clk(clk), .rst(rst), .stall(stall),
		.outReady(outReady));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [27:0] expect_out(logic [3:0] s, logic [11:0] f,
		logic [11:0] v, logic c, logic l, logic k);
		logic t;
		t = ((s < 4'hc) ? ing[s] : 1'b0) || |(f & egr) ||
			(v == 12'h023 && flag) || (c && ctl[0]) || (l && ctl[1]) || k;
		return {f, t ? tgt : 12'h000, t & tgt[11], ctl[6:4]};
	endfunction

	task automatic chk(logic [31:0] g, logic [31:0] x);
		comparisons++;
		if (g !== x) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask

	task automatic ahb(logic w, logic [31:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (!hreadyout);
		rd = hrdata;
	endtask

	task automatic cfg(logic [11:0] i, logic [11:0] g, logic [11:0] t,
		logic [6:0] c, logic f);
		ing = i;
		egr = g;
		tgt = t;
		ctl = c;
		flag = f;
		ahb(1'b1, OFF_INGRESS_EN, {20'h0, i});
		ahb(1'b1, OFF_EGRESS_MASK, {20'h0, g});
		ahb(1'b1, OFF_TARGET_MASK, {20'h0, t});
		ahb(1'b1, OFF_CTRL, {25'h0, c});
		ahb(1'b1, 32'h404, {28'h0, f, 3'h0});
		ahb(1'b1, OFF_COPY_COUNT, 32'h0);
		ahb(1'b0, OFF_TARGET_MASK, 32'h0);
		chk(rd, {20'h0, t});
		nCopy = 0;
		repeat (40) begin
			inValid <= ($urandom % 4) != 0;
			inSrcPort <= 4'($urandom % 14);
			inFwdMask <= 12'($urandom);
			inVid <= ($urandom % 2) ? 12'h023 : 12'($urandom);
			inCpuBound <= 1'($urandom);
			inLearnFrame <= 1'($urandom);
			inClassifierCopy <= ($urandom % 5) == 0;
			do @(posedge clk); while (inValid && !inReady);
		end
		inValid <= 1'b0;
		while (q.size() != 0) @(posedge clk);
		ahb(1'b0, OFF_COPY_COUNT, 32'h0);
		chk(rd, nCopy);
	endtask

	// Expected results are queued at the take edge, compared at the output.
	always @(posedge clk) begin
		if (!rst && inValid && inReady) begin
			e = expect_out(inSrcPort, inFwdMask, inVid, inCpuBound,
				inLearnFrame, inClassifierCopy);
			q.push_back(e);
			nCopy += (e[15:4] != 12'h000);
		end
		if (!rst && outValid && outReady) begin
			chk({4'h0, outFwdMask, outCopyMask, outCpuCopy, outCpuQueue},
				{4'h0, q.pop_front()});
		end
	end

	always @(posedge clk) begin
		stall <= ($urandom % 4) == 0;
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		{hsel, hwrite, inValid, inCpuBound, inLearnFrame} = 5'h00;
		{inClassifierCopy, stall, flag} = 3'h0;
		{haddr, hwdata, htrans, inSrcPort, inFwdMask, inVid} = 94'h0;
		{ing, egr, tgt, ctl} = 43'h0;
		hsize = 3'h2;
		rst = 1'b1;
		void'($urandom(32'h0b92));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, OFF_TARGET_MASK, 32'h0);
		chk(rd, {20'h0, RST_TARGET_MASK});
		ahb(1'b0, 32'h100, 32'h0);
		chk(rd, 32'h0);
		cfg(12'h008, 12'h008, 12'h004, 7'h00, 1'b0);
		cfg(12'h000, 12'h000, 12'h800, 7'h53, 1'b1);
		cfg(12'h0a1, 12'h300, 12'h804, 7'h23, 1'b1);
		give_verdict();
	end
endmodule
`default_nettype wire
